// ---- design/adc_result_flags.v ----
// Purpose: result slots 5..7, event flags, unread tracking, interrupt level
// Assumes: register port is already decoded from the serial interface
// Notes:   one clock, synchronous active-high reset, global clock enable
`timescale 1ns/1ps
`default_nettype none
`include "adc_defs.vh"

// Function
// - store result only into selected slot
// - over flag on upper limit or overrange
// - under flag on lower limit or underrange
// - range flags sticky, cleared by flags read
// - gain overrange flag on oversize gain coefficient
// - gain flag clears on read or valid calibration
// - eight unread bits, set write, clear read
// - unread indication is OR, not cleared by flags read
// - continuous results set unread bit again
// - start operand selects slot and mode
// - wait flag set done, clear read/start
// - calibration flag set ready, clear read/start
// - sequence flag set pass, clear read/start/wrap
// - conversion flag set result, clear read/start/next
// - flags register reports state and interrupt causes
// - interrupt on enabled flag, mask resets 0x000001
module adc_result_flags (
    // clock, reset, enable
    input  wire        i_clock,
    input  wire        i_rst,
    input  wire        i_enable,
    // register port
    input  wire [7:0]  i_reg_addr,
    input  wire        i_reg_wr,
    input  wire        i_reg_rd,
    input  wire [23:0] i_reg_wdata,
    output reg  [23:0] o_reg_rdata,
    // converter results
    input  wire        i_result_valid,
    input  wire [23:0] i_result,
    input  wire [2:0]  i_result_slot_select,
    input  wire [2:0]  i_sequencer_slot_select,
    input  wire        i_sequencer_active,
    input  wire        i_digital_over,
    input  wire        i_digital_under,
    input  wire        i_result_soon,
    input  wire [71:0] i_upper_limit,
    input  wire [71:0] i_lower_limit,
    // operation events
    input  wire        i_wait_done,
    input  wire        i_cal_done,
    input  wire        i_gain_cal_done,
    input  wire        i_gain_cal_over,
    input  wire        i_sequence_pass,
    input  wire        i_sequence_wrap,
    // start register writes
    input  wire        i_wait_trigger,
    input  wire        i_cal_trigger,
    input  wire        i_sequence_trigger,
    input  wire        i_conversion_trigger,
    input  wire [7:0]  i_conversion_operand,
    // outputs
    output reg  [2:0]  o_conv_slot,
    output reg         o_conv_continuous,
    output wire        o_data_unread,
    output reg         o_interrupt_out_n
);

    // ======================================================================
    // state
    reg  [23:0] slot_r [0:2];
    reg  [7:0]  over_r;
    reg  [7:0]  under_r;
    reg  [7:0]  unread_r;
    reg         gain_r;
    reg         wait_r;
    reg         cal_r;
    reg         seq_r;
    reg         conv_r;
    reg         cont_mode_r;
    reg  [23:0] mask_r;

    wire [2:0]  result_slot_select;
    wire        flags_rd;
    wire [23:0] flags;
    wire [7:0]  stored;
    wire [7:0]  slot_rd;
    wire [7:0]  over_set;
    wire [7:0]  under_set;

    // ======================================================================
    // destination and decode
    assign result_slot_select     = i_sequencer_active ? i_sequencer_slot_select
                                         : i_result_slot_select;
    assign flags_rd = i_reg_rd && (i_reg_addr == `ADC_ADDR_FLAGS);

    genvar k;
    generate
        for (k = 0; k < `ADC_NSLOTS; k = k + 1) begin : g_slot
            wire hit_lim;
            wire low_lim;
            assign stored[k]  = i_result_valid && (result_slot_select == k);
            assign slot_rd[k] = i_reg_rd &&
                                (i_reg_addr == (`ADC_ADDR_SLOT0 + k));
            if (k >= `ADC_FIRST_KEPT) begin : g_kept
                wire [23:0] up;
                wire [23:0] lo;
                assign up = i_upper_limit[(k-`ADC_FIRST_KEPT)*24 +: 24];
                assign lo = i_lower_limit[(k-`ADC_FIRST_KEPT)*24 +: 24];
                assign hit_lim = (i_result > up);
                assign low_lim = (i_result < lo);
                always @(posedge i_clock) begin
                    if (i_enable) begin
                        if (stored[k]) begin
                            slot_r[k-`ADC_FIRST_KEPT] <= i_result;
                        end else if (i_reg_wr &&
                                     i_reg_addr == (`ADC_ADDR_SLOT0 + k)) begin
                            slot_r[k-`ADC_FIRST_KEPT] <= i_reg_wdata;
                        end
                    end
                end
            end else begin : g_ext
                // limits of these slots live outside, only range events count
                assign hit_lim = 1'b0;
                assign low_lim = 1'b0;
            end
            assign over_set[k]  = stored[k] && (hit_lim || i_digital_over);
            assign under_set[k] = stored[k] && (low_lim || i_digital_under);
        end
    endgenerate

    // ======================================================================
    // flags register image, bits 6..4 tied low
    assign flags = {over_r, under_r, gain_r, 3'h0,
                    wait_r, cal_r, seq_r, conv_r};
    assign o_data_unread = |unread_r;

    // ======================================================================
    // sticky flags: set always wins over any clear
    always @(posedge i_clock) begin
        if (i_rst) begin
            over_r      <= `ADC_ZERO8;
            under_r     <= `ADC_ZERO8;
            unread_r    <= `ADC_ZERO8;
            gain_r      <= 1'b0;
            wait_r      <= 1'b0;
            cal_r       <= 1'b0;
            seq_r       <= 1'b0;
            conv_r      <= 1'b0;
        end else if (i_enable) begin
            over_r   <= (over_r  & {8{~flags_rd}}) | over_set;
            under_r  <= (under_r & {8{~flags_rd}}) | under_set;
            unread_r <= (unread_r & ~slot_rd) | stored;
            gain_r   <= (gain_r & ~flags_rd &
                         ~(i_gain_cal_done && !i_gain_cal_over)) |
                        (i_gain_cal_done && i_gain_cal_over);
            wait_r   <= (wait_r & ~flags_rd & ~i_wait_trigger) |
                        i_wait_done;
            cal_r    <= (cal_r & ~flags_rd & ~i_cal_trigger) |
                        i_cal_done;
            seq_r    <= (seq_r & ~flags_rd & ~i_sequence_trigger &
                         ~i_sequence_wrap) | i_sequence_pass;
            conv_r   <= (conv_r & ~flags_rd & ~i_conversion_trigger &
                         ~(cont_mode_r && i_result_soon)) |
                        i_result_valid;
        end
    end

    // ======================================================================
    // start operand decode: slot in bits 6..4, mode in bits 1..0
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_conv_slot       <= 3'h0;
            o_conv_continuous <= 1'b0;
            cont_mode_r       <= 1'b0;
        end else if (i_enable && i_conversion_trigger) begin
            o_conv_slot       <= i_conversion_operand[6:4];
            o_conv_continuous <= (i_conversion_operand[1:0] == `ADC_MODE_CONT);
            cont_mode_r       <= (i_conversion_operand[1:0] == `ADC_MODE_CONT);
        end
    end

    // ======================================================================
    // enable mask, interrupt, read data
    always @(posedge i_clock) begin
        if (i_rst) begin
            mask_r            <= `ADC_MASK_RESET;
            o_interrupt_out_n <= 1'b1;
            o_reg_rdata       <= `ADC_ZERO24;
        end else if (i_enable) begin
            if (i_reg_wr && i_reg_addr == `ADC_ADDR_MASK) begin
                mask_r <= i_reg_wdata;
            end
            o_interrupt_out_n <= ~|(flags & mask_r);
            if (i_reg_rd) begin
                if (i_reg_addr == `ADC_ADDR_SLOT5) begin
                    o_reg_rdata <= slot_r[0];
                end else if (i_reg_addr == `ADC_ADDR_SLOT6) begin
                    o_reg_rdata <= slot_r[1];
                end else if (i_reg_addr == `ADC_ADDR_SLOT7) begin
                    o_reg_rdata <= slot_r[2];
                end else if (i_reg_addr == `ADC_ADDR_FLAGS) begin
                    o_reg_rdata <= flags;
                end else if (i_reg_addr == `ADC_ADDR_MASK) begin
                    o_reg_rdata <= mask_r;
                end else begin
                    o_reg_rdata <= `ADC_ZERO24;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ---- design/adc_defs.vh ----
// Purpose: constants of the result slot and event flag block
// Assumes: included by bare name
// Notes:   addresses are register indices on the serial register port
`ifndef ADC_DEFS_VH
`define ADC_DEFS_VH

// ==========================================================================
// register addresses
`define ADC_ADDR_SLOT0      8'h30
`define ADC_ADDR_SLOT5      8'h35
`define ADC_ADDR_SLOT6      8'h36
`define ADC_ADDR_SLOT7      8'h37
`define ADC_ADDR_FLAGS      8'h38
`define ADC_ADDR_MASK       8'h39

// ==========================================================================
// event flag field positions
`define ADC_OVER_HI         23
`define ADC_OVER_LO         16
`define ADC_UNDER_HI        15
`define ADC_UNDER_LO        8
`define ADC_GAIN_BIT        7
`define ADC_WAIT_BIT        3
`define ADC_CAL_BIT         2
`define ADC_SEQ_BIT         1
`define ADC_CONV_BIT        0

// ==========================================================================
// reset values and widths
`define ADC_MASK_RESET      24'h000001
`define ADC_ZERO24          24'h000000
`define ADC_ZERO8           8'h00
`define ADC_NSLOTS          8
`define ADC_FIRST_KEPT      5
`define ADC_MODE_CONT       2'h1

`endif

// ---- verification/adc_flags_props.sv ----
// Purpose: port assertions for the result slot and event flag block
// Assumes: clock enable held high by the bench
// Notes:   one clock, reset disables every check
`timescale 1ns/1ps
`default_nettype none
module adc_flags_props (
    // clock and register port
    input wire logic        i_clock,
    input wire logic        i_rst,
    input wire logic [7:0]  i_reg_addr,
    input wire logic        i_reg_rd,
    input wire logic [23:0] o_reg_rdata,
    // converter side
    input wire logic        i_result_valid,
    input wire logic        i_wait_done,
    input wire logic        i_gain_cal_done,
    input wire logic        i_gain_cal_over,
    input wire logic        i_conversion_trigger,
    input wire logic [7:0]  i_conversion_operand,
    input wire logic [2:0]  o_conv_slot,
    input wire logic        o_data_unread,
    input wire logic        o_interrupt_out_n
);
    // ====================
    // checks
    wire       rd38 = i_reg_rd & (i_reg_addr == 8'h38);
    wire [2:0] op_slot = i_conversion_operand[6:4];
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    a_reset_irq_idle: assert property ($fell(i_rst) |-> o_interrupt_out_n)
        else $error("irq low after reset");
    a_conv_slot_load: assert property (i_conversion_trigger |=> o_conv_slot == $past(op_slot))
        else $error("slot not loaded");
    a_unread_on_result: assert property (i_result_valid |=> o_data_unread)
        else $error("unread not set");
    a_flags_read_unread: assert property (rd38 & o_data_unread |=> o_data_unread)
        else $error("unread cleared by flag read");
    a_rdata_holds: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data moved");
    a_reserved_zero: assert property (rd38 |=> o_reg_rdata[6:4] == 3'h0)
        else $error("reserved bits set");
    a_gain_over_seen: assert property (i_gain_cal_done & i_gain_cal_over ##1 rd38
        |=> o_reg_rdata[7]) else $error("gain flag lost");
    a_wait_seen: assert property (i_wait_done ##1 rd38 |=> o_reg_rdata[3])
        else $error("wait flag lost");
endmodule
bind adc_result_flags adc_flags_props props_u (.i_clock, .i_rst, .i_reg_addr, .i_reg_rd,
    .o_reg_rdata, .i_result_valid, .i_wait_done, .i_gain_cal_done, .i_gain_cal_over,
    .i_conversion_trigger, .i_conversion_operand, .o_conv_slot, .o_data_unread,
    .o_interrupt_out_n);
`default_nettype wire

// ---- verification/adc_host_model.sv ----
// Purpose: host end of the register port
// Assumes: access is entered just after a falling edge
// Notes:   released address and data lines carry the inverse of the last value, strobes go low
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
    // clock and read data
    input  wire logic        i_clock,
    input  wire logic [23:0] i_rdata,
    // register strobes
    output var  logic [7:0]  o_addr = 8'h0,
    output var  logic        o_rd = 1'b0,
    output var  logic        o_wr = 1'b0,
    output var  logic [23:0] o_wdata = 24'h0
);
    // ====================
    // one access, read data taken a cycle after the strobe
    task automatic access(input logic [7:0] a, input logic w, input logic [23:0] d,
                          output logic [23:0] q);
        {o_addr, o_wdata, o_wr, o_rd} = {a, d, w, !w};
        @(negedge i_clock);
        q = i_rdata;
        {o_addr, o_wdata, o_wr, o_rd} = {~a, ~d, 2'h0};
    endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench for adc_result_flags
// Assumes: inputs change on the falling edge
// Notes:   flags, unread bits and slots mirrored in integers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        i_clock = 1'b0, i_rst = 1'b1, i_enable = 1'b1, i_result_valid = 1'b0;
    logic        i_sequencer_active = 1'b0, i_conversion_trigger = 1'b0;
    logic [2:0]  i_result_slot_select = 3'h0, i_sequencer_slot_select = 3'h0;
    logic [7:0]  i_conversion_operand = 8'h0;
    logic [11:0] ev = 12'h0;
    logic [23:0] i_result = 24'h0, q;
    logic [71:0] i_upper_limit, i_lower_limit;
    wire         i_reg_wr, i_reg_rd, i_wait_done, i_cal_done, i_gain_cal_done, i_gain_cal_over;
    wire         i_sequence_pass, i_sequence_wrap, i_wait_trigger, i_cal_trigger;
    wire         i_sequence_trigger, i_result_soon, i_digital_over, i_digital_under;
    wire         o_conv_continuous, o_data_unread, o_interrupt_out_n;
    wire [2:0]   o_conv_slot;
    wire [7:0]   i_reg_addr;
    wire [23:0]  i_reg_wdata, o_reg_rdata;
    int          miscompares = 0, checks = 0, mf = 0, un = 0, s, ul[8], ll[8], sl[8];
    int          sets[6] = '{'h1, 'h2, 'h10, 'h10, 'hc, 'h1f};
    int          clrs[6] = '{'h40, 'h80, 'h20, 'h100, 'h4, 'h0};
    assign {i_digital_under, i_digital_over, i_result_soon, i_sequence_trigger, i_cal_trigger,
            i_wait_trigger, i_sequence_wrap, i_sequence_pass, i_gain_cal_over,
            i_gain_cal_done, i_cal_done, i_wait_done} = ev;
    adc_host_model host_u (.i_clock, .i_rdata(o_reg_rdata), .o_addr(i_reg_addr),
        .o_rd(i_reg_rd), .o_wr(i_reg_wr), .o_wdata(i_reg_wdata));
    adc_result_flags dut_u (.*);
    initial forever #5 i_clock = ~i_clock;
    // ====================
    // tasks
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input int e);
        host_u.access(a, 1'b0, 24'h0, q);
        chk(q, e[23:0]);
        if (a == 8'h38) mf = 0;
        if (a[7:3] == 5'h6) un &= ~(1 << a[2:0]);
    endtask
    task automatic pulse(input logic [11:0] e);
        mf &= ~{24'h0, e[2] & !e[3], 3'h0, e[6], e[7], e[8] | e[5], 1'b0};
        mf |= {e[2] & e[3], 3'h0, e[0], e[1], e[4], 1'b0};
        ev = e;
        @(negedge i_clock);
        ev = 12'h0;
    endtask
    task automatic result(input int d, input logic [23:0] v, input logic o, input logic u);
        i_sequencer_active = $urandom;
        i_sequencer_slot_select = i_sequencer_active ? d[2:0] : ~d[2:0];
        i_result_slot_select = i_sequencer_active ? ~d[2:0] : d[2:0];
        {i_result_valid, i_result, ev} = {1'b1, v, u, o, 10'h0};
        if (d > 4) sl[d] = v;
        un |= 1 << d;
        mf |= 1 | (o | v > ul[d]) << (16 + d) | (u | v < ll[d]) << (8 + d);
        @(negedge i_clock);
        {i_result_valid, i_result, ev} = {1'b0, ~v, 12'h0};
    endtask
    // ====================
    // scenarios
    initial begin
        void'($urandom(32'h7ac0098a));
        for (int k = 0; k < 8; k++) begin
            ul[k] = k > 4 ? 'h800000 + $urandom % 'h400000 : 'hffffff;
            ll[k] = k > 4 ? $urandom % 'h400000 : 0;
            sl[k] = 0;
        end
        i_upper_limit = {ul[7][23:0], ul[6][23:0], ul[5][23:0]};
        i_lower_limit = {ll[7][23:0], ll[6][23:0], ll[5][23:0]};
        repeat (16) @(posedge i_clock);
        @(negedge i_clock);
        i_rst = 1'b0;
        chk(o_interrupt_out_n, 1'b1);
        rd(8'h39, 1);
        host_u.access(8'h38, 1'b1, 24'hffffff, q);
        rd(8'h38, 0);
        rd(8'h3a, 0);
        for (int k = 0; k < 2; k++) begin
            {i_conversion_trigger, i_conversion_operand} = {1'b1, k ? 8'h61 : 8'h70};
            @(negedge i_clock);
            i_conversion_trigger = 1'b0;
            chk({o_conv_slot, o_conv_continuous}, k ? 4'hd : 4'he);
        end
        for (int k = 0; k < 40; k++) begin
            s = k ? $urandom % 8 : 2;
            result(s, $urandom, $urandom % 4 == 0, $urandom % 4 == 0);
            rd(k % 2 ? 8'h38 : 8'h30 + s, k % 2 ? mf : sl[s]);
            chk(o_interrupt_out_n, 1'b0);
            chk(o_data_unread, un != 0);
        end
        for (int k = 0; k < 6; k++) begin
            pulse(sets[k]);
            rd(8'h38, mf);
            pulse(sets[k]);
            if (clrs[k] != 0) pulse(clrs[k]);
            rd(8'h38, mf);
        end
        result(2, 24'h1, 1'b0, 1'b0);
        pulse(12'h200);
        mf &= ~1;
        rd(8'h38, mf);
        ev = 12'h1;
        rd(8'h38, mf);
        ev = 12'h0;
        rd(8'h38, 8);
        for (int k = 0; k < 8; k++) rd(8'h30 + k, sl[k]);
        chk(o_data_unread, 1'b0);
        complete_run;
    end
    initial begin
        repeat (5000) @(posedge i_clock);
        miscompares++;
        complete_run;
    end
endmodule
`default_nettype wire
